// ==== hw/adc_pin_params.svh ====
`ifndef ADC_PIN_PARAMS_SVH
`define ADC_PIN_PARAMS_SVH

// register addresses and reset value
`define GPC_ADDR 6'h06
`define ID_ADDR 6'h07
`define GPC_RESET 16'h0800

// configuration field positions
`define GPC_OUT23_EN 13
`define GPC_SELECTOR 12
`define GPC_HOLD_EN 11
`define GPC_FAULT_MODE_HI 10
`define GPC_FAULT_MODE_LO 9
`define GPC_FAULT_DATA 8
`define GPC_OUT3_LEVEL 7
`define GPC_OUT2_LEVEL 6
`define GPC_PIN1_IN_EN 5
`define GPC_PIN0_IN_EN 4
`define GPC_PIN1_OUT_EN 3
`define GPC_PIN0_OUT_EN 2
`define GPC_PIN1_LEVEL 1
`define GPC_PIN0_LEVEL 0

// serial frame layout: command byte then 16 data bits, msb first
`define CMD_WEN_BIT 7
`define CMD_READ_BIT 6
`define CMD_BITS 8
`define FRAME_BITS 24

`endif

// ==== hw/adc_pin_pkg.sv ====
package adc_pin_pkg;

  // error pin modes
  typedef enum logic [1:0] {
    FAULT_OFF = 2'b00,
    FAULT_INPUT = 2'b01,
    FAULT_OPEN_DRAIN = 2'b10,
    FAULT_OUTPUT = 2'b11
  } fault_mode_type;

  // serial frame phases
  typedef enum logic [1:0] {
    PHASE_COMMAND = 2'b00,
    PHASE_DATA = 2'b01,
    PHASE_DONE = 2'b10
  } phase_type;

endpackage : adc_pin_pkg

// ==== hw/serial_reg_port.sv ====
`timescale 1ns/10ps
`include "adc_pin_params.svh"

module serial_reg_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial pins, sampled on clk_i
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // register side
  output logic [5:0] addr_o,
  output logic wr_pulse_o,
  output logic [15:0] wr_data_o,
  input wire logic [15:0] rd_data_i
);

  adc_pin_pkg::phase_type phase_reg, phase_next;
  logic sclk_prev_reg;
  logic [4:0] count_reg;
  logic [15:0] shift_reg;
  logic read_reg;
  logic load_reg;
  logic miso_reg;

  wire sclk_rise = sclk_i & ~sclk_prev_reg;
  wire sclk_fall = ~sclk_i & sclk_prev_reg;
  wire [4:0] count_inc = count_reg + 5'h01;
  wire last_cmd = sclk_rise && (count_inc == 5'(`CMD_BITS));
  wire last_data = sclk_rise && (count_inc == 5'(`FRAME_BITS));
  // a command without the enable bit low is not ours; the frame is then skipped
  wire cmd_ok = ~shift_reg[`CMD_WEN_BIT - 1];
  // in a read data phase the word only shifts out on falls, never in on rises
  wire read_phase = (phase_reg == adc_pin_pkg::PHASE_DATA) && read_reg;

  // phase walk: command, then data, then idle until select rises
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      adc_pin_pkg::PHASE_COMMAND: begin
        if (last_cmd) begin
          phase_next = cmd_ok ? adc_pin_pkg::PHASE_DATA : adc_pin_pkg::PHASE_DONE;
        end
      end
      adc_pin_pkg::PHASE_DATA: begin
        if (last_data) begin
          phase_next = adc_pin_pkg::PHASE_DONE;
        end
      end
      adc_pin_pkg::PHASE_DONE: phase_next = adc_pin_pkg::PHASE_DONE;
      default: phase_next = adc_pin_pkg::PHASE_COMMAND;
    endcase
    if (cs_n_i) begin
      phase_next = adc_pin_pkg::PHASE_COMMAND;
    end
  end

  // shifter: sample on rising clock edge, present on falling edge
  always_ff @(posedge clk_i) begin
    sclk_prev_reg <= reset_i ? 1'b1 : sclk_i;
    if (reset_i || cs_n_i) begin
      phase_reg <= adc_pin_pkg::PHASE_COMMAND;
      count_reg <= 5'h00;
      shift_reg <= 16'h0000;
      read_reg <= 1'b0;
      load_reg <= 1'b0;
      miso_reg <= 1'b0;
      addr_o <= 6'h00;
      wr_pulse_o <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      wr_pulse_o <= 1'b0;
      if (sclk_rise) begin
        count_reg <= count_inc;
      end
      load_reg <= last_cmd;
      if (last_cmd) begin
        addr_o <= {shift_reg[4:0], mosi_i};
        read_reg <= shift_reg[`CMD_READ_BIT - 1];
      end else if (load_reg) begin
        shift_reg <= rd_data_i; // one cycle late, so the read mux already sees the new address
      end else if (sclk_rise && !read_phase) begin
        shift_reg <= {shift_reg[14:0], mosi_i};
      end else if (sclk_fall && phase_reg == adc_pin_pkg::PHASE_DATA && read_reg) begin
        miso_reg <= shift_reg[15];
        shift_reg <= {shift_reg[14:0], 1'b0};
      end
      if (last_data && phase_reg == adc_pin_pkg::PHASE_DATA && !read_reg) begin
        wr_pulse_o <= 1'b1;
      end
    end
  end

  assign miso_o = miso_reg;
  // write data is the word just shifted in, held stable for the pulse
  assign wr_data_o = shift_reg;

endmodule : serial_reg_port

// ==== hw/adc_gpio_sync_error_pins.sv ====
`timescale 1ns/10ps
`include "adc_pin_params.svh"

module adc_gpio_sync_error_pins #(
  parameter int ERROR_BITS = 4,
  parameter logic [15:0] PART_ID = 16'h1230 // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial register port
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // channel sequencer side
  input wire logic [2:0] channel_index_i,
  input wire logic channel_switch_i,
  input wire logic multi_channel_i,
  input wire logic alternate_hold_mode_i,
  input wire logic [ERROR_BITS-1:0] status_error_bits_i,
  output logic modulator_reset_o,
  output logic conversion_wait_o,
  output logic pin_error_flag_o,
  // hold pin, active low
  input wire logic hold_n_i,
  // general pin zero
  input wire logic general_pin_zero_i,
  output logic general_pin_zero_o,
  output logic general_pin_zero_oe_n_o,
  // general pin one
  input wire logic general_pin_one_i,
  output logic general_pin_one_o,
  output logic general_pin_one_oe_n_o,
  // general outputs two and three
  output logic general_output_two_o,
  output logic general_output_two_oe_n_o,
  output logic general_output_three_o,
  output logic general_output_three_oe_n_o,
  // error pin
  input wire logic fault_pin_i,
  output logic fault_pin_o,
  output logic fault_pin_oe_n_o
);

  logic [15:0] config_reg;
  logic [5:0] addr;
  logic wr_pulse;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic hold_wait_reg;

  // serial slave: host reaches both registers through it
  serial_reg_port port_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .addr_o(addr),
    .wr_pulse_o(wr_pulse),
    .wr_data_o(wr_data),
    .rd_data_i(rd_data)
  );

  // field decode
  wire outputs_two_three_enable = config_reg[`GPC_OUT23_EN];
  wire external_selector_control = config_reg[`GPC_SELECTOR];
  wire hold_input_enable = config_reg[`GPC_HOLD_EN];
  wire [1:0] fault_mode_bits = config_reg[`GPC_FAULT_MODE_HI:`GPC_FAULT_MODE_LO];
  wire fault_pin_data = config_reg[`GPC_FAULT_DATA];
  wire output_three_level = config_reg[`GPC_OUT3_LEVEL];
  wire output_two_level = config_reg[`GPC_OUT2_LEVEL];
  wire pin_one_input_enable = config_reg[`GPC_PIN1_IN_EN];
  wire pin_zero_input_enable = config_reg[`GPC_PIN0_IN_EN];
  wire pin_one_output_enable = config_reg[`GPC_PIN1_OUT_EN];
  wire pin_zero_output_enable = config_reg[`GPC_PIN0_OUT_EN];
  wire pin_one_level = config_reg[`GPC_PIN1_LEVEL];
  wire pin_zero_level = config_reg[`GPC_PIN0_LEVEL];

  wire fault_is_input = fault_mode_bits == adc_pin_pkg::FAULT_INPUT;
  wire fault_is_open_drain = fault_mode_bits == adc_pin_pkg::FAULT_OPEN_DRAIN;
  wire fault_is_output = fault_mode_bits == adc_pin_pkg::FAULT_OUTPUT;

  // register writes; bits 15 and 14 are not kept and read as zero
  wire config_write = wr_pulse && (addr == `GPC_ADDR);
  wire [15:0] config_mask = 16'h3FFF;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      config_reg <= `GPC_RESET;
    end else if (config_write) begin
      config_reg <= wr_data & config_mask;
    end
  end

  // readback: input modes show the pins, write-only levels show zero
  wire rd_fault_data = fault_is_input ? fault_pin_i : fault_pin_data;
  wire rd_pin_one = pin_one_input_enable ? general_pin_one_i : pin_one_level;
  wire rd_pin_zero = pin_zero_input_enable ? general_pin_zero_i : pin_zero_level;
  wire [15:0] config_view = {config_reg[15:9], rd_fault_data, 2'b00,
                             config_reg[5:2], rd_pin_one, rd_pin_zero};

  // read mux; the identification word cannot be written
  assign rd_data = (addr == `GPC_ADDR) ? config_view :
                   (addr == `ID_ADDR) ? PART_ID :
                   16'h0000;

  // pin one and zero drive: selector takes them over for the channel index
  wire pin_zero_drive = external_selector_control | pin_zero_output_enable;
  wire pin_one_drive = external_selector_control | pin_one_output_enable;
  wire pin_zero_value = external_selector_control ? channel_index_i[0] : pin_zero_level;
  wire pin_one_value = external_selector_control ? channel_index_i[1] : pin_one_level;

  // outputs two and three need their enable; selector also owns output two
  wire out_two_drive = external_selector_control | outputs_two_three_enable;
  wire out_two_value = external_selector_control ? channel_index_i[2] : output_two_level;
  wire out_three_drive = outputs_two_three_enable;
  wire out_three_value = output_three_level;

  // error pin: open drain only ever pulls low, general output drives both levels
  wire any_status_error = |status_error_bits_i;
  wire fault_drive = fault_is_output | (fault_is_open_drain & any_status_error);
  wire fault_value = fault_is_output ? fault_pin_data : 1'b0;

  // sensed error pin is active low and only counts in input mode
  wire fault_sensed = fault_is_input & ~fault_pin_i;

  // hold pin: plain mode resets at once, alternate mode only stalls a switch
  wire alternate_active = alternate_hold_mode_i & multi_channel_i;
  wire plain_hold = hold_input_enable & ~alternate_active & ~hold_n_i;
  wire hold_wait_set = hold_input_enable & alternate_active & channel_switch_i & ~hold_n_i;
  wire hold_wait_clear = hold_n_i | ~hold_input_enable | ~alternate_active;

  // the wait holds until the pin rises, the hold enable drops or alternate mode ends; a new switch with the pin low wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hold_wait_reg <= 1'b0;
    end else if (hold_wait_set) begin
      hold_wait_reg <= 1'b1;
    end else if (hold_wait_clear) begin
      hold_wait_reg <= 1'b0;
    end
  end

  // all pin and status outputs registered; one cycle from pins to outputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      general_pin_zero_o <= 1'b0;
      general_pin_zero_oe_n_o <= 1'b1;
      general_pin_one_o <= 1'b0;
      general_pin_one_oe_n_o <= 1'b1;
      general_output_two_o <= 1'b0;
      general_output_two_oe_n_o <= 1'b1;
      general_output_three_o <= 1'b0;
      general_output_three_oe_n_o <= 1'b1;
      fault_pin_o <= 1'b0;
      fault_pin_oe_n_o <= 1'b1;
      pin_error_flag_o <= 1'b0;
      modulator_reset_o <= 1'b0;
      conversion_wait_o <= 1'b0;
    end else begin
      general_pin_zero_o <= pin_zero_value;
      general_pin_zero_oe_n_o <= ~pin_zero_drive;
      general_pin_one_o <= pin_one_value;
      general_pin_one_oe_n_o <= ~pin_one_drive;
      general_output_two_o <= out_two_value;
      general_output_two_oe_n_o <= ~out_two_drive;
      general_output_three_o <= out_three_value;
      general_output_three_oe_n_o <= ~out_three_drive;
      fault_pin_o <= fault_value;
      fault_pin_oe_n_o <= ~fault_drive;
      pin_error_flag_o <= fault_sensed;
      modulator_reset_o <= plain_hold;
      conversion_wait_o <= hold_wait_set | (hold_wait_reg & ~hold_wait_clear);
    end
  end

  // the sequencer pass limit of eight channels is the host's to respect

endmodule : adc_gpio_sync_error_pins

// ==== tb/adc_gpio_sync_error_pins_checker.sv ====
`timescale 1ns/10ps
module adc_gpio_sync_error_pins_checker (
  // clock, reset, select
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  // sequencer side and pins
  input wire logic [2:0] channel_index_i,
  input wire logic channel_switch_i,
  input wire logic multi_channel_i,
  input wire logic alternate_hold_mode_i,
  input wire logic hold_n_i,
  input wire logic fault_pin_i,
  input wire logic modulator_reset_o,
  input wire logic conversion_wait_o,
  input wire logic pin_error_flag_o,
  input wire logic general_pin_zero_o,
  input wire logic general_pin_zero_oe_n_o,
  input wire logic general_pin_one_o,
  input wire logic general_pin_one_oe_n_o,
  input wire logic general_output_two_o,
  input wire logic general_output_two_oe_n_o,
  input wire logic general_output_three_oe_n_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_RESET_IDLE: assert property ($fell(reset_i) |-> general_pin_zero_oe_n_o && general_pin_one_oe_n_o
    && general_output_two_oe_n_o && general_output_three_oe_n_o) else $error("pin driven after reset");
  AST_HOLD_CAUSE: assert property (modulator_reset_o |->
    $past(!hold_n_i && !(alternate_hold_mode_i && multi_channel_i))) else $error("reset without hold");
  AST_HOLD_RESET: assert property (!hold_n_i && !alternate_hold_mode_i |=> modulator_reset_o)
    else $error("hold low ignored");
  AST_WAIT_START: assert property (channel_switch_i && !hold_n_i && alternate_hold_mode_i
    && multi_channel_i |=> conversion_wait_o) else $error("conversion not held");
  AST_WAIT_END: assert property (conversion_wait_o && hold_n_i |=> !conversion_wait_o)
    else $error("conversion wait stuck");
  AST_FAULT_SENSE: assert property (pin_error_flag_o |-> $past(!fault_pin_i))
    else $error("error flag without low pin");
  AST_OUT_PAIR: assert property (!general_output_three_oe_n_o |-> !general_output_two_oe_n_o)
    else $error("output three without two");
  // enables come only from the register, which changes only inside a frame
  AST_OE_QUIET: assert property (cs_n_i [*3] |-> $stable(general_pin_zero_oe_n_o)
    && $stable(general_pin_one_oe_n_o)) else $error("enable moved outside frame");
  // output two driven alone means selector mode
  AST_SELECTOR: assert property (!general_output_two_oe_n_o && general_output_three_oe_n_o |->
    {general_output_two_o, general_pin_one_o, general_pin_zero_o} == $past(channel_index_i))
    else $error("selector pins off sequence");
endmodule : adc_gpio_sync_error_pins_checker

bind adc_gpio_sync_error_pins adc_gpio_sync_error_pins_checker u_checker (.clk_i, .reset_i, .cs_n_i,
  .channel_index_i, .channel_switch_i, .multi_channel_i, .alternate_hold_mode_i, .hold_n_i, .fault_pin_i,
  .modulator_reset_o, .conversion_wait_o, .pin_error_flag_o, .general_pin_zero_o, .general_pin_zero_oe_n_o,
  .general_pin_one_o, .general_pin_one_oe_n_o, .general_output_two_o, .general_output_two_oe_n_o,
  .general_output_three_oe_n_o);

// ==== tb/spi_host_model.sv ====
`timescale 1ns/10ps
module spi_host_model (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // idle: clock high, deselected
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // three cycles per level, safely above the two-cycle minimum
  task automatic frame(input logic [23:0] word, output logic [15:0] rd);
    int i;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (i = 23; i >= 0; i--) begin
      repeat (3) @(posedge clk_i);
      #1 sclk_o = 1'b0;
      mosi_o = word[i];
      repeat (3) @(posedge clk_i);
      #1 sclk_o = 1'b1;
      if (i < 16) rd[i] = miso_i;
    end
    repeat (4) @(posedge clk_i);
    #1 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line shows no stale value
  endtask : frame
endmodule : spi_host_model

// ==== tb/adc_gpio_sync_error_pins_tb_top.sv ====
`timescale 1ns/10ps
`include "adc_pin_params.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("FAIL %0t got %h want %h", $time, a, e); end end
module adc_gpio_sync_error_pins_tb_top;
  typedef struct {logic [15:0] cfg; logic [3:0] err; logic fin; logic [4:0] oe; logic [4:0] lvl;
    logic [15:0] rd;} row_type;
  localparam logic [15:0] ID_CODE = 16'h4C5A; // arbitrary value
  // pin order {zero, one, two, three, fault}; levels listed for driven pins only
  row_type rows [10] = '{'{16'h080D, 4'h0, 1'b1, 5'h07, 5'h10, 16'h080D}, '{16'h28C0, 4'h0, 1'b1, 5'h19, 5'h06, 16'h2800},
    '{16'h2880, 4'h0, 1'b1, 5'h19, 5'h02, 16'h2800}, '{16'h0E00, 4'h0, 1'b1, 5'h1E, 5'h00, 16'h0E00},
    '{16'h0F00, 4'h0, 1'b1, 5'h1E, 5'h01, 16'h0F00}, '{16'h0C00, 4'h0, 1'b1, 5'h1F, 5'h00, 16'h0C00},
    '{16'h0C00, 4'h2, 1'b1, 5'h1E, 5'h00, 16'h0C00}, '{16'h0A00, 4'h0, 1'b1, 5'h1F, 5'h00, 16'h0B00},
    '{16'h0800, 4'h0, 1'b0, 5'h1F, 5'h00, 16'h0800}, '{16'h0A00, 4'h0, 1'b0, 5'h1F, 5'h00, 16'h0A00}};
  logic clk_i = 1'b0, reset_i = 1'b1, hold_n = 1'b1, sw = 1'b0, multi = 1'b0, alt = 1'b0, fault_ext = 1'b1;
  logic [2:0] index = 3'h0;
  logic [3:0] err = 4'h0;
  logic [1:0] pin_ext = 2'h0;
  logic [15:0] rd;
  logic sclk, cs_n, mosi, miso, mod_rst, conv_wait, err_flag, p0, p0_oe, p1, p1_oe, o2, o2_oe, o3, o3_oe, f, f_oe;
  logic p0_w, p1_w, f_w;
  logic [4:0] oe, lvl;
  int err_total = 0, samples_checked = 0, cycles = 0, k;

  // wire levels: the far side drives where the block does not, fault line from fault_ext
  assign p0_w = p0_oe ? pin_ext[0] : p0;
  assign p1_w = p1_oe ? pin_ext[1] : p1;
  assign f_w = f_oe ? fault_ext : f;
  assign oe = {p0_oe, p1_oe, o2_oe, o3_oe, f_oe};
  assign lvl = {p0, p1, o2, o3, f} & ~oe;

  always #5 clk_i = ~clk_i;

  spi_host_model u_spi_host_model (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

  adc_gpio_sync_error_pins #(.PART_ID(ID_CODE)) u_adc_gpio_sync_error_pins (.clk_i(clk_i), .reset_i(reset_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .channel_index_i(index), .channel_switch_i(sw),
    .multi_channel_i(multi), .alternate_hold_mode_i(alt), .status_error_bits_i(err), .modulator_reset_o(mod_rst),
    .conversion_wait_o(conv_wait), .pin_error_flag_o(err_flag), .hold_n_i(hold_n), .general_pin_zero_i(p0_w),
    .general_pin_zero_o(p0), .general_pin_zero_oe_n_o(p0_oe), .general_pin_one_i(p1_w), .general_pin_one_o(p1),
    .general_pin_one_oe_n_o(p1_oe), .general_output_two_o(o2), .general_output_two_oe_n_o(o2_oe),
    .general_output_three_o(o3), .general_output_three_oe_n_o(o3_oe), .fault_pin_i(f_w), .fault_pin_o(f),
    .fault_pin_oe_n_o(f_oe));

  task automatic acc(input logic rw, input logic [5:0] a, input logic [15:0] d);
    u_spi_host_model.frame({1'b0, rw, a, d}, rd);
  endtask : acc

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // a hang counts as a mismatch; the run needs roughly 4200 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 25000) begin
      err_total++;
      results();
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    acc(1'b1, `GPC_ADDR, 16'h0000);
    `CHK(rd, `GPC_RESET)
    acc(1'b0, `ID_ADDR, 16'hFFFF);
    acc(1'b1, `ID_ADDR, 16'h0000);
    `CHK(rd, ID_CODE)
    done("reset");
    foreach (rows[k]) begin
      err = rows[k].err;
      fault_ext = rows[k].fin;
      acc(1'b0, `GPC_ADDR, rows[k].cfg);
      `CHK(oe, rows[k].oe)
      `CHK(lvl, rows[k].lvl)
      acc(1'b1, `GPC_ADDR, 16'h0000);
      `CHK(rd, rows[k].rd)
    end
    `CHK(err_flag, 1'b1)
    done("rows");
    // input enables: sensed levels replace stored ones on readback
    pin_ext = 2'b10;
    acc(1'b0, `GPC_ADDR, 16'h0830);
    acc(1'b1, `GPC_ADDR, 16'h0000);
    `CHK(rd, 16'h0832)
    pin_ext = 2'b01;
    acc(1'b1, `GPC_ADDR, 16'h0000);
    `CHK({rd, p0_oe, p1_oe}, 18'h20C7)
    done("inputs");
    acc(1'b0, `GPC_ADDR, 16'h1800);
    for (k = 0; k < 8; k++) begin
      index = k[2:0];
      sw = 1'b1;
      @(posedge clk_i);
      #1 sw = 1'b0;
      @(posedge clk_i);
      #1 `CHK({o2, p1, p0}, k[2:0])
    end
    acc(1'b0, 6'h10, 16'h0001);
    done("selector");
    hold_n = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 `CHK(mod_rst, 1'b1)
    hold_n = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 `CHK(mod_rst, 1'b0)
    alt = 1'b1;
    multi = 1'b1;
    hold_n = 1'b0;
    sw = 1'b1;
    @(posedge clk_i);
    #1 sw = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 `CHK({conv_wait, mod_rst}, 2'b10)
    hold_n = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 `CHK(conv_wait, 1'b0)
    done("hold");
    results();
  end
endmodule : adc_gpio_sync_error_pins_tb_top
